// *** shared/sso_defs.svh ***
/*
 Register offsets, field positions, reset values, output function codes
 and timing figures of the servo status output block.
 Assumes inclusion by the package, the design file and the bench only.
*/
`ifndef SSO_DEFS_SVH
`define SSO_DEFS_SVH

`define SSO_A_CTRL 8'h00
`define SSO_A_INPOS_OFF 8'h01
`define SSO_A_W1A 8'h02
`define SSO_A_W1B 8'h03
`define SSO_A_W2A 8'h04
`define SSO_A_W2B 8'h05
`define SSO_A_FUNC0 8'h08
`define SSO_A_STATUS 8'h10
`define SSO_A_POS 8'h11

`define SSO_CTRL_AUX_MODE 0
`define SSO_N_TERMS 4
`define SSO_AUX_DEF 8'hFF
`define SSO_INPOS_OFF_RST 16'h000A

`define SSO_FC_LIFE 8'h2E
`define SSO_FC_AUX0 8'h3C
`define SSO_FC_AUX7 8'h43
`define SSO_FC_PRESET 8'h4B
`define SSO_FC_ALARM 8'h4C
`define SSO_FC_PERMIT 8'h4F
`define SSO_FC_CONT_DONE 8'h50
`define SSO_FC_CHG_DONE 8'h51
`define SSO_FC_CMD_DONE 8'h52
`define SSO_FC_WIN1 8'h53
`define SSO_FC_WIN2 8'h54

`define SSO_CLK_HZ 10000000
`define SSO_CONT_OFF_MS 50
`define SSO_CONT_OFF_CYC ((`SSO_CONT_OFF_MS * `SSO_CLK_HZ) / 1000)

`endif

// *** shared/sso_pkg.sv ***
/*
 Types of the servo status output block: event carrier, status carrier,
 command pulses and the continuation state.
 Assumes sso_defs.svh for the number of output terminals.
*/
`default_nettype none
`include "sso_defs.svh"

package sso_pkg;

    typedef enum logic [1:0] {CS_IDLE, CS_PERMIT, CS_DONE, CS_HOLD} sso_cont_t;

    typedef struct packed {
        logic cap_life;
        logic fan_life;
        logic alarm;
        logic abs_sys;
        logic preset_begin;
        logic preset_end;
        logic motion_start;
        logic motion_end;
        logic pos_complete;
        logic cmd_exhausted;
        logic dwell;
        logic abort;
        logic onfly_start;
        logic zero_move;
        logic [7:0] aux_code;
        logic signed [31:0] cur_pos;
    } sso_ev_t;

    typedef struct packed {
        logic life_warn;
        logic alarm_ok;
        logic preset_done;
        logic cont_permit;
        logic cont_done;
        logic change_done;
        logic cmd_done;
        logic win1;
        logic win2;
        logic inpos;
        logic [7:0] aux;
    } sso_stat_t;

    typedef struct packed {
        logic start_go;
        logic cont_go;
        logic change_go;
    } sso_go_t;

    typedef struct packed {
        logic [2:0] sy1;
        logic [2:0] sy2;
        logic [2:0] sy3;
        logic [2:0] pf;
        logic [2:0] pp;
        sso_cont_t cont;
        logic [31:0] hold_cnt;
        logic [15:0] off_cnt;
        sso_stat_t stat;
        sso_go_t go;
        logic [`SSO_N_TERMS-1:0] terms;
        logic [31:0] rdata;
        logic aux_mode;
        logic [15:0] off_time;
        logic [1:0][31:0] wa;
        logic [1:0][31:0] wb;
        logic [`SSO_N_TERMS-1:0][7:0] func;
    } sso_state_t;

endpackage : sso_pkg

`default_nettype wire

// *** logic/sso_status_out.sv ***
/*
 Status output generator of a servo amplifier toward a host controller:
 life warning, auxiliary code, preset done, alarm contact, continuation and
 change handshakes, command done, position windows and terminal mapping.
 Assumes the motion core on the same clock drives ev_i, and the host drives
 the three command pins asynchronously; they pass three flip-flops first.
 Assumes a bus master that never raises both strobes in one cycle and
 takes read data in the cycle after the read strobe only.
 Assumes ce_i comes from the same clock domain as every input but the three command pins.
*/
`include "sso_defs.svh"
`timescale 1ns/1ns
`default_nettype none

module sso_status_out #(
    parameter int unsigned CONT_OFF_CYC = `SSO_CONT_OFF_CYC
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    input wire logic [7:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [31:0] rdata_o,
    input wire sso_pkg::sso_ev_t ev_i,
    input wire logic start_pin_i,
    input wire logic cont_pin_i,
    input wire logic change_pin_i,
    output sso_pkg::sso_stat_t stat_o,
    output sso_pkg::sso_go_t go_o,
    output logic [`SSO_N_TERMS-1:0] term_o
);
    import sso_pkg::*;

    sso_state_t q;
    sso_state_t d;

    // Level of one output function for a terminal function code
    function automatic logic fsel(input logic [7:0] code, input sso_stat_t s);
        logic [7:0] bitx;
        bitx = code - `SSO_FC_AUX0;
        if (code == `SSO_FC_LIFE) begin
            return s.life_warn;
        end else if (code >= `SSO_FC_AUX0 && code <= `SSO_FC_AUX7) begin
            return s.aux[bitx[2:0]];
        end else if (code == `SSO_FC_PRESET) begin
            return s.preset_done;
        end else if (code == `SSO_FC_ALARM) begin
            return s.alarm_ok;
        end else if (code == `SSO_FC_PERMIT) begin
            return s.cont_permit;
        end else if (code == `SSO_FC_CONT_DONE) begin
            return s.cont_done;
        end else if (code == `SSO_FC_CHG_DONE) begin
            return s.change_done;
        end else if (code == `SSO_FC_CMD_DONE) begin
            return s.cmd_done;
        end else if (code == `SSO_FC_WIN1) begin
            return s.win1;
        end else if (code == `SSO_FC_WIN2) begin
            return s.win2;
        end else begin
            return 1'b0;
        end
    endfunction : fsel

    // Window compare of the current position against two settings
    function automatic logic win(input logic [31:0] a, input logic [31:0] b,
                                 input logic signed [31:0] p);
        if (a == b) begin
            return 1'b0;
        end else if ($signed(a) < $signed(b)) begin
            return p >= $signed(a) && p <= $signed(b);
        end else begin
            return p >= $signed(a) || p <= $signed(b);
        end
    endfunction : win

    // Command done counts for starts only when a terminal carries it
    function automatic logic mapped(input logic [`SSO_N_TERMS-1:0][7:0] f,
                                    input logic [7:0] code);
        logic hit;
        hit = 1'b0;
        for (int i = 0; i < `SSO_N_TERMS; i++) begin
            if (f[i] == code) begin
                hit = 1'b1;
            end
        end
        return hit;
    endfunction : mapped

    // Register decode results
    localparam logic [3:0] RS_NONE = 4'h0;
    localparam logic [3:0] RS_CTRL = 4'h1;
    localparam logic [3:0] RS_INPOS = 4'h2;
    localparam logic [3:0] RS_W1A = 4'h3;
    localparam logic [3:0] RS_W1B = 4'h4;
    localparam logic [3:0] RS_W2A = 4'h5;
    localparam logic [3:0] RS_W2B = 4'h6;
    localparam logic [3:0] RS_FUNC = 4'h7;
    localparam logic [3:0] RS_STAT = 4'h8;
    localparam logic [3:0] RS_POS = 4'h9;

    // Register addressed by the bus, shared by the write and read paths
    function automatic logic [3:0] reg_dec(input logic [7:0] a);
        logic [7:0] off;
        off = a - `SSO_A_FUNC0;
        if (a == `SSO_A_CTRL) begin
            return RS_CTRL;
        end else if (a == `SSO_A_INPOS_OFF) begin
            return RS_INPOS;
        end else if (a == `SSO_A_W1A) begin
            return RS_W1A;
        end else if (a == `SSO_A_W1B) begin
            return RS_W1B;
        end else if (a == `SSO_A_W2A) begin
            return RS_W2A;
        end else if (a == `SSO_A_W2B) begin
            return RS_W2B;
        end else if (off < 8'(`SSO_N_TERMS)) begin
            return RS_FUNC;
        end else if (a == `SSO_A_STATUS) begin
            return RS_STAT;
        end else if (a == `SSO_A_POS) begin
            return RS_POS;
        end else begin
            return RS_NONE;
        end
    endfunction : reg_dec

    logic [2:0] rise;
    logic [7:0] fidx;
    logic cont_req;
    logic [3:0] asel;
    logic [2:0] pf_nx;
    logic [`SSO_N_TERMS-1:0] term_lvl;
    logic [1:0] win_lvl;

    // Pin filter per command pin: a level counts once stages two and three agree
    generate
        for (genvar g = 0; g < 3; g++) begin : g_pin
            assign pf_nx[g] = (q.sy2[g] == q.sy3[g]) ? q.sy3[g] : q.pf[g];
        end
    endgenerate

    // One function selector per output terminal
    generate
        for (genvar g = 0; g < `SSO_N_TERMS; g++) begin : g_term
            assign term_lvl[g] = fsel(q.func[g], q.stat);
        end
    endgenerate

    // Both position windows use the same comparator
    generate
        for (genvar g = 0; g < 2; g++) begin : g_win
            assign win_lvl[g] = win(q.wa[g], q.wb[g], ev_i.cur_pos);
        end
    endgenerate

    always_comb begin
        d = q;
        d.go = '0;
        rise = q.pf & ~q.pp;
        fidx = addr_i - `SSO_A_FUNC0;
        asel = reg_dec(addr_i);
        cont_req = 1'b0;

        // Pin filter: accept a level once second and third stage agree
        d.sy1 = {change_pin_i, cont_pin_i, start_pin_i};
        d.sy2 = q.sy1;
        d.sy3 = q.sy2;
        d.pf = pf_nx;
        d.pp = q.pf;

        // Plain status levels
        d.stat.life_warn = ev_i.cap_life | ev_i.fan_life;
        d.stat.alarm_ok = ~ev_i.alarm;

        // Preset done: begin clears, finish sets when abs_sys is high, set wins
        if (ev_i.preset_begin) begin
            d.stat.preset_done = 1'b0;
        end
        if (ev_i.abs_sys && ev_i.preset_end) begin
            d.stat.preset_done = 1'b1;
        end

        // Start acceptance and command done
        if (q.off_cnt != 16'h0000) begin
            d.off_cnt = q.off_cnt - 16'h0001;
        end
        if (rise[0] && (!mapped(q.func, `SSO_FC_CMD_DONE) || q.stat.cmd_done)) begin
            d.go.start_go = 1'b1;
            d.stat.cmd_done = 1'b0;
            if (ev_i.zero_move) begin
                d.off_cnt = q.off_time;
            end
        end
        if (ev_i.cmd_exhausted && !ev_i.dwell) begin
            d.stat.cmd_done = 1'b1;
        end
        if (ev_i.abort) begin
            d.stat.cmd_done = 1'b1;
        end
        d.stat.inpos = ev_i.pos_complete && d.off_cnt == 16'h0000;

        // Auxiliary code, any value passed through as is
        if (!q.aux_mode) begin
            if (ev_i.motion_end) begin
                d.stat.aux = `SSO_AUX_DEF;
            end else if (ev_i.motion_start) begin
                d.stat.aux = ev_i.aux_code;
            end
        end else if (ev_i.motion_end) begin
            d.stat.aux = ev_i.aux_code;
        end

        // Continuation handshake
        cont_req = rise[1] && q.stat.cont_permit;
        case (q.cont)
            CS_IDLE: begin
                d.stat.cont_permit = 1'b0;
                if (ev_i.onfly_start) begin
                    d.stat.cont_permit = 1'b1;
                    d.cont = CS_PERMIT;
                end
            end
            CS_PERMIT, CS_HOLD: begin
                if (q.cont == CS_HOLD) begin
                    if (q.hold_cnt == 32'h0000_0000) begin
                        d.stat.cont_permit = 1'b0;
                        d.cont = CS_IDLE;
                    end else begin
                        d.hold_cnt = q.hold_cnt - 32'h0000_0001;
                    end
                end else if (ev_i.motion_end) begin
                    d.hold_cnt = CONT_OFF_CYC - 32'h0000_0001;
                    d.cont = CS_HOLD;
                end
                if (cont_req) begin
                    d.go.cont_go = 1'b1;
                    d.stat.cont_done = 1'b1;
                    d.stat.cont_permit = 1'b0;
                    d.cont = CS_DONE;
                end
            end
            CS_DONE: begin
                if (!q.pf[1]) begin
                    d.stat.cont_done = 1'b0;
                    d.stat.cont_permit = 1'b1;
                    d.cont = CS_PERMIT;
                end
            end
            default: begin
                d.cont = CS_IDLE;
            end
        endcase
        if (ev_i.abort) begin
            d.cont = CS_IDLE;
            d.stat.cont_permit = 1'b0;
            d.stat.cont_done = 1'b0;
        end

        // Change handshake
        if (!q.pf[2]) begin
            d.stat.change_done = 1'b0;
        end
        if (rise[2] && !ev_i.pos_complete && q.cont != CS_IDLE) begin
            d.go.change_go = 1'b1;
            d.stat.change_done = 1'b1;
        end

        // Position windows
        d.stat.win1 = win_lvl[0];
        d.stat.win2 = win_lvl[1];

        // Terminal mapping
        d.terms = term_lvl;

        // Register writes
        if (wr_i) begin
            if (asel == RS_CTRL) begin
                d.aux_mode = wdata_i[`SSO_CTRL_AUX_MODE];
            end else if (asel == RS_INPOS) begin
                d.off_time = wdata_i[15:0];
            end else if (asel == RS_W1A) begin
                d.wa[0] = wdata_i;
            end else if (asel == RS_W1B) begin
                d.wb[0] = wdata_i;
            end else if (asel == RS_W2A) begin
                d.wa[1] = wdata_i;
            end else if (asel == RS_W2B) begin
                d.wb[1] = wdata_i;
            end else if (asel == RS_FUNC) begin
                d.func[fidx[1:0]] = wdata_i[7:0];
            end
        end

        // Register reads, data valid in the next cycle only
        d.rdata = 32'h0000_0000;
        if (rd_i) begin
            if (asel == RS_CTRL) begin
                d.rdata = {31'h0, q.aux_mode};
            end else if (asel == RS_INPOS) begin
                d.rdata = {16'h0000, q.off_time};
            end else if (asel == RS_W1A) begin
                d.rdata = q.wa[0];
            end else if (asel == RS_W1B) begin
                d.rdata = q.wb[0];
            end else if (asel == RS_W2A) begin
                d.rdata = q.wa[1];
            end else if (asel == RS_W2B) begin
                d.rdata = q.wb[1];
            end else if (asel == RS_FUNC) begin
                d.rdata = {24'h000000, q.func[fidx[1:0]]};
            end else if (asel == RS_STAT) begin
                d.rdata = {8'h00, q.cont, q.terms, q.stat};
            end else if (asel == RS_POS) begin
                d.rdata = ev_i.cur_pos;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            q <= '0;
            q.stat.aux <= `SSO_AUX_DEF;
            q.stat.cmd_done <= 1'b1;
            q.off_time <= `SSO_INPOS_OFF_RST;
        end else if (ce_i) begin
            q <= d;
        end
    end

    assign rdata_o = q.rdata;
    assign stat_o = q.stat;
    assign go_o = q.go;
    assign term_o = q.terms;

endmodule : sso_status_out

`default_nettype wire

// *** verification/sso_props.sv ***
/* Concurrent checks of the status output block.
   Bound to sso_status_out and sees its ports only. */
`timescale 1ns/1ns
`default_nettype none
module sso_props (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    input wire sso_pkg::sso_ev_t ev_i,
    input wire sso_pkg::sso_stat_t stat_o,
    input wire sso_pkg::sso_go_t go_o
);
    import sso_pkg::*;
    default clocking @(posedge clk_i);
    endclocking
    default disable iff (!rst_n_i);
    a_life_warn_on: assert property (
        ce_i && (ev_i.cap_life || ev_i.fan_life) |=> stat_o.life_warn)
        else $error("life warning missing");
    a_alarm_contact: assert property (
        ce_i && ev_i.alarm |=> !stat_o.alarm_ok)
        else $error("alarm contact still high");
    a_preset_set: assert property (
        ce_i && ev_i.abs_sys && ev_i.preset_end |=> stat_o.preset_done)
        else $error("preset done missing");
    a_cont_gate: assert property (
        go_o.cont_go |-> $past(stat_o.cont_permit))
        else $error("continuation taken without permit");
    a_cont_done_set: assert property (
        go_o.cont_go |-> stat_o.cont_done && !stat_o.cont_permit)
        else $error("continuation flags wrong");
    a_change_done_set: assert property (
        go_o.change_go |-> stat_o.change_done && !$past(ev_i.pos_complete))
        else $error("change flags wrong");
    a_start_clears: assert property (
        go_o.start_go && !$past(ev_i.cmd_exhausted) && !$past(ev_i.abort) |-> !stat_o.cmd_done)
        else $error("command done not cleared at start");
    a_exhaust_sets: assert property (
        ce_i && ev_i.cmd_exhausted && !ev_i.dwell |=> stat_o.cmd_done)
        else $error("command done not set");
    a_dwell_holds: assert property (
        ce_i && ev_i.dwell && !ev_i.abort && !stat_o.cmd_done |=> !stat_o.cmd_done)
        else $error("command done set during dwell");
    a_abort_sets: assert property (
        ce_i && ev_i.abort |=> stat_o.cmd_done)
        else $error("command done not set on abort");
endmodule : sso_props
bind sso_status_out sso_props u_props (.clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(ce_i),
    .ev_i(ev_i), .stat_o(stat_o), .go_o(go_o));
`default_nettype wire

// *** verification/sso_host_model.sv ***
/* Host controller model driving the three command pins.
   Assumes stat_i from the status block on the same clock. */
`timescale 1ns/1ns
`default_nettype none
module sso_host_model (
    input wire logic clk_i,
    input wire sso_pkg::sso_stat_t stat_i,
    output logic start_pin_o,
    output logic cont_pin_o,
    output logic change_pin_o
);
    import sso_pkg::*;
    initial begin
        start_pin_o = 1'b0;
        cont_pin_o = 1'b0;
        change_pin_o = 1'b0;
    end
    task automatic drive(input int w, input logic v);
        if (w == 0) start_pin_o <= v;
        else if (w == 1) cont_pin_o <= v;
        else change_pin_o <= v;
    endtask : drive
    // Gate off only where a refusal is wanted; slow holds the pin past the answer
    task automatic press(input int w, input logic gate, input int slow);
        int n;
        n = 0;
        while (gate && n < 200 && !(w == 0 ? stat_i.cmd_done : stat_i.cont_permit)) begin
            @(posedge clk_i);
            n++;
        end
        drive(w, 1'b1);
        n = 0;
        while (n < 12 && !(w == 1 ? stat_i.cont_done : w == 2 && stat_i.change_done)) begin
            @(posedge clk_i);
            n++;
        end
        repeat (slow) @(posedge clk_i);
        drive(w, 1'b0);
        repeat (6) @(posedge clk_i);
    endtask : press
endmodule : sso_host_model
`default_nettype wire

// *** verification/tb_top.sv ***
/* Self-checking bench of the status output block.
   Drives bus and events at the clock edge; host pins come from the host model. */
`include "sso_defs.svh"
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    import sso_pkg::*;
    localparam int unsigned OFF = 20;
    localparam int P_BEG = 49, P_END = 48, M_ST = 47, M_END = 46, EXH = 44, ABT = 42, FLY = 41;
    logic clk_i, rst_n_i, ce_i, wr_i, rd_i, sp, cp, gp;
    logic [7:0] addr_i, c;
    logic [31:0] wdata_i, rdata_o, r;
    logic signed [31:0] p;
    logic [3:0] term_o;
    logic [7:0] pv [6] = '{8'h63, 8'h64, 8'h96, 8'hC8, 8'hC9, 8'h00};
    sso_ev_t ev;
    sso_stat_t st;
    sso_go_t go;
    int bad_count, n_tests, cyc, ns, nc, ng, i, b;
    sso_status_out #(.CONT_OFF_CYC(OFF)) dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(ce_i),
        .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .ev_i(ev), .start_pin_i(sp), .cont_pin_i(cp), .change_pin_i(gp), .stat_o(st),
        .go_o(go), .term_o(term_o));
    sso_host_model host (.clk_i(clk_i), .stat_i(st), .start_pin_o(sp), .cont_pin_o(cp),
        .change_pin_o(gp));
    initial begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end
    always @(posedge clk_i) begin
        cyc++;
        if (go.start_go) ns++;
        if (go.cont_go) nc++;
        if (go.change_go) ng++;
        if (cyc == 5000) begin
            bad_count++;
            finish_test();
        end
    end
    function automatic logic win_exp(input logic signed [31:0] a, z, q);
        return (a == z) ? 1'b0 : (a < z) ? (q >= a && q <= z) : (q >= a || q <= z);
    endfunction : win_exp
    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
    endtask : tick
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        tick(1);
        wr_i <= 1'b0;
        tick(1);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        addr_i <= a;
        rd_i <= 1'b1;
        tick(1);
        rd_i <= 1'b0;
        @(negedge clk_i);
        chk(rdata_o, e);
        tick(1);
    endtask : rd
    task automatic pulse(input int k);
        ev[k] <= 1'b1;
        tick(1);
        ev[k] <= 1'b0;
        tick(2);
    endtask : pulse
    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : finish_test
    initial begin
        {rst_n_i, wr_i, rd_i, addr_i, wdata_i} = '0;
        ce_i = 1'b1;
        ev = '0;
        {bad_count, n_tests, cyc, ns, nc, ng} = '0;
        r = $urandom(84423);
        tick(12);
        rst_n_i <= 1'b1;
        tick(1);
        rd(`SSO_A_INPOS_OFF, 32'h0000000A);
        rd(8'h20, 32'h00000000);
        chk(32'(st.aux), 32'h000000FF);
        wr(`SSO_A_FUNC0, 32'(`SSO_FC_LIFE));
        wr(`SSO_A_FUNC0 + 8'h01, 32'(`SSO_FC_ALARM));
        wr(`SSO_A_FUNC0 + 8'h03, 32'(`SSO_FC_CMD_DONE));
        for (i = 0; i < 8; i++) begin
            r = $urandom;
            ev.cap_life <= r[0];
            ev.fan_life <= r[1];
            ev.alarm <= r[2];
            tick(3);
            chk(32'(term_o[0]), 32'(r[0] | r[1]));
            chk(32'(term_o[1]), 32'(!r[2]));
        end
        ev.alarm <= 1'b0;
        tick(3);
        ce_i <= 1'b0;
        ev.alarm <= 1'b1;
        tick(3);
        chk(32'(term_o[1]), 32'h00000001);
        ce_i <= 1'b1;
        tick(3);
        chk(32'(term_o[1]), 32'h00000000);
        ev.alarm <= 1'b0;
        for (i = 0; i < 4; i++) begin
            c = (i == 0) ? 8'h00 : 8'($urandom);
            ev.aux_code <= c;
            pulse(M_ST);
            chk(32'(st.aux), 32'(c));
            for (b = 0; b < 8; b++) begin
                wr(`SSO_A_FUNC0 + 8'h02, 32'(`SSO_FC_AUX0) + 32'(b));
                tick(3);
                chk(32'(term_o[2]), 32'(c[b]));
            end
            pulse(M_END);
            chk(32'(st.aux), 32'h000000FF);
        end
        wr(`SSO_A_CTRL, 32'h00000001);
        c = 8'($urandom);
        ev.aux_code <= c;
        pulse(M_ST);
        chk(32'(st.aux), 32'h000000FF);
        pulse(M_END);
        ev.aux_code <= ~c;
        tick(4);
        chk(32'(st.aux), 32'(c));
        wr(`SSO_A_CTRL, 32'h00000000);
        for (i = 0; i < 2; i++) begin
            ev.abs_sys <= i[0];
            pulse(P_BEG);
            chk(32'(st.preset_done), 32'h00000000);
            pulse(P_END);
            chk(32'(st.preset_done), 32'(i[0]));
        end
        host.press(0, 1'b1, 0);
        chk(32'(st.cmd_done), 32'h00000000);
        host.press(0, 1'b0, 0);
        chk(32'(ns), 32'h00000001);
        ev.dwell <= 1'b1;
        pulse(EXH);
        chk(32'(st.cmd_done), 32'h00000000);
        ev.dwell <= 1'b0;
        pulse(EXH);
        chk(32'(st.cmd_done), 32'h00000001);
        host.press(0, 1'b1, 0);
        ev.dwell <= 1'b1;
        pulse(ABT);
        chk(32'(st.cmd_done), 32'h00000001);
        ev.dwell <= 1'b0;
        host.press(1, 1'b0, 0);
        chk(32'(nc), 32'h00000000);
        pulse(FLY);
        chk(32'(st.cont_permit), 32'h00000001);
        host.press(1, 1'b1, 3);
        chk(32'(nc), 32'h00000001);
        chk(32'({st.cont_done, st.cont_permit}), 32'h00000001);
        host.press(2, 1'b1, 2);
        chk(32'({ng[0], st.change_done}), 32'h00000002);
        ev.pos_complete <= 1'b1;
        host.press(2, 1'b0, 0);
        chk(32'(ng), 32'h00000001);
        ev.pos_complete <= 1'b0;
        pulse(M_END);
        tick(OFF - 6);
        chk(32'(st.cont_permit), 32'h00000001);
        tick(8);
        chk(32'(st.cont_permit), 32'h00000000);
        wr(`SSO_A_W1A, 32'h00000064);
        wr(`SSO_A_W1B, 32'h000000C8);
        wr(`SSO_A_W2A, 32'h00000096);
        wr(`SSO_A_W2B, 32'h00000096);
        rd(`SSO_A_W1B, 32'h000000C8);
        for (i = 0; i < 12; i++) begin
            p = (i < 6) ? 32'(pv[i]) : $urandom_range(400) - 100;
            ev.cur_pos <= p;
            tick(3);
            chk(32'(st.win1), 32'(win_exp(32'h64, 32'hC8, p)));
            chk(32'(st.win2), 32'h00000000);
        end
        rd(`SSO_A_POS, 32'(p));
        wr(`SSO_A_INPOS_OFF, 32'h0000001E);
        ev.pos_complete <= 1'b1;
        ev.zero_move <= 1'b1;
        tick(2);
        chk(32'(st.inpos), 32'h00000001);
        host.press(0, 1'b1, 0);
        chk(32'({st.inpos, term_o[3]}), 32'h00000000);
        ev.zero_move <= 1'b0;
        tick(20);
        chk(32'(st.inpos), 32'h00000001);
        pulse(EXH);
        chk(32'(term_o[3]), 32'h00000001);
        rst_n_i <= 1'b0;
        tick(2);
        rst_n_i <= 1'b1;
        tick(1);
        chk(32'({st.aux, st.cmd_done, st.inpos}), 32'h000003FE);
        rd(`SSO_A_INPOS_OFF, 32'h0000000A);
        finish_test();
    end
endmodule : tb_top
`default_nettype wire
